/* File: logic/mcc_regs.v */
// What this block does
// [R1] Upper prescale nibble holds current-mode sampling ratio, software read/write.
// [R2] Lower nibble is timer prescaler, bumped up or down by ratio events.
// [R3] Mask bit 7 reads hysteresis comparator level; writes ignored.
// [R4] Mask bit 6 reads current loop comparator level; writes ignored.
// [R5] Mask bits 5,4,3,2,0 enable ratio, overflow, emergency, zero, commute.
// [R6] Demag-end interrupt enabled only with its mask and a demag enable.
// [R7] Flag bit 7 always reads zero.
// [R8] Flag bits 4..0 mark pending overflow, emergency, zero, demag, commute.
// [R9] In autoswitched mode ratio flags are only pending event indicators.
// [R10] Switched mode: ratio-up flag bumps prescaler, shifts timers right at commute.
// [R11] Switched mode: ratio-down flag lowers prescaler, shifts timers left.
// [R12] Output enable clear tristates outputs and stops unit clocks.
// [R13] Control bit 6 resets the unit registers except the synchronisers, MOTOR_OUT and read data, not the whole chip.
// [R14] Bit 5 picks sensorless or sensor mode; the demag PWM select is honoured in both.
// [R15] Without direct access preloads transfer only at commutation.
// [R16] Direct access: phase write drives outputs now, timer clock off.
// [R17] Control bit 3 selects voltage (0) or current (1) mode.
// [R18] Bit 2 selects switched or autoswitched; compare read-only when auto.
// [R19] Control bit 1 enables the current feedback filter.
// [R20] Bit 0 picks previous or latest capture; compare is weight*capture/32.
// [R21] Preload bits take effect at next commutation unless direct access.
// [R22] Software clears flags by writing zero; request holds while enabled.
`include "mcc_consts.vh"

module mcc_regs (
  input wire CLOCK,
  input wire RESETN,
  input wire [`MCC_ADDR_W-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output wire [7:0] RDATA,
  input wire HYST_COMP,
  input wire CURR_COMP,
  input wire EMERGENCY_N,
  input wire COMMUTE_EV,
  input wire ZERO_CROSS_EV,
  input wire DEMAG_END_EV,
  input wire RATIO_UP_EV,
  input wire RATIO_DOWN_EV,
  input wire HW_DEMAG_EN,
  input wire SW_DEMAG_EN,
  input wire DEMAG_PWM_WR,
  input wire DEMAG_PWM_DATA,
  input wire PHASE_WR,
  input wire [5:0] PHASE_DATA,
  input wire [5:0] POLARITY,
  input wire [7:0] WEIGHT,
  input wire [7:0] PREV_CAPTURE,
  input wire [7:0] LATEST_CAPTURE,
  output wire [5:0] MOTOR_OUT,
  output wire [5:0] MOTOR_OE,
  output wire TIMER_CLK_EN,
  output wire TIMER_SHIFT_R,
  output wire TIMER_SHIFT_L,
  output wire [3:0] STEP_PRESCALE,
  output wire [3:0] SAMPLE_RATIO,
  output wire CURRENT_MODE,
  output wire SENSOR_MODE,
  output wire AUTO_COMMUTE,
  output wire FILTER_EN,
  output wire DEMAG_PWM_ACT,
  output wire [7:0] NEXT_COMPARE,
  output wire UNIT_SOFT_RESET,
  output wire IRQ_REQ
);

////////////////////////////////////////////////////////////////////////////////

reg [2:0] sync1_ff;
reg [2:0] sync2_ff;
reg emerg_prev_ff;
reg [3:0] sa_ff;
reg [3:0] st_ff;
reg [5:0] mask_ff;
reg [6:0] flag_ff;
reg [7:0] ctl_ff;
reg [7:0] cmp_ff;
reg [5:0] phase_pre_ff;
reg [5:0] phase_act_ff;
reg os2_pre_ff;
reg os2_act_ff;
reg [5:0] out_ff;
reg [5:0] oe_ff;
reg clk_en_ff;
reg shr_ff;
reg shl_ff;
reg irq_ff;
reg [7:0] rdata_ff;

// The comparator and emergency levels come from pins, so they pass two
// flip-flops first. The emergency stage resets high, which reads as no
// alarm, so the first cycles after reset do not raise a false stop.
wire hyst_s = sync2_ff[0];
wire curr_s = sync2_ff[1];
wire emerg_n_s = sync2_ff[2];
// The emergency pin acts on its synchronised level, so outputs release
// three cycles late; a truly asynchronous cut belongs in the pad logic.
wire emerg_fall = emerg_prev_ff & ~emerg_n_s;

wire output_enable_master = ctl_ff[`MCC_C_MOE];
wire direct = ctl_ff[`MCC_C_DIRECT];
wire auto_mode = ctl_ff[`MCC_C_AUTO];
wire soft_rst = ctl_ff[`MCC_C_RST];
// With the outputs disabled the unit clocks are stopped, so every event
// pulse is dropped rather than queued for later.
wire run = output_enable_master; // [R12]
wire comm = COMMUTE_EV & run & ~direct; // [R15] [R16]
wire direct_load = PHASE_WR & run & direct; // [R16]
wire up_ev = RATIO_UP_EV & run;
wire down_ev = RATIO_DOWN_EV & run;

// Writes land at the edge that samples the strobe; the bus never waits.
// The compare register turns read-only while the hardware owns it.
wire wr_pre = WR & (ADDR == `MCC_A_PRESCALE);
wire wr_mask = WR & (ADDR == `MCC_A_MASK);
wire wr_flag = WR & (ADDR == `MCC_A_FLAG);
wire wr_ctl = WR & (ADDR == `MCC_A_CTRL_A);
wire wr_cmp = WR & (ADDR == `MCC_A_COMPARE) & ~auto_mode; // [R18]

////////////////////////////////////////////////////////////////////////////////

// Dividing by 32 is a plain bit slice of the product. Any bit above the
// slice means the quotient no longer fits the compare register, which is
// reported as a multiplier overflow.
wire [7:0] cap_sel = ctl_ff[`MCC_C_CAPSEL] ?
  LATEST_CAPTURE : PREV_CAPTURE; // [R20]
wire [`MCC_PROD_W-1:0] product = WEIGHT * cap_sel; // [R20]
wire [7:0] quotient = product[`MCC_Q_HI:`MCC_Q_LO]; // [R20]
wire mul_ovf = |product[`MCC_OVF_HI:`MCC_OVF_LO];
wire zero_ev = ZERO_CROSS_EV & run;
wire auto_load = zero_ev & auto_mode;

////////////////////////////////////////////////////////////////////////////////

// Switched mode acts on a pending ratio flag at commutation only.
wire sw_up = comm & ~auto_mode & flag_ff[`MCC_F_UP]; // [R10]
wire sw_down = comm & ~auto_mode & flag_ff[`MCC_F_DOWN]; // [R11]
wire hw_inc = (auto_mode & up_ev) | sw_up; // [R2] [R9]
wire hw_dec = (auto_mode & down_ev) | sw_down; // [R2] [R9]

// A flag set by hardware in the same cycle that software clears it stays
// set, so no event is lost to a badly timed clear.
reg [6:0] flag_set;
reg [6:0] flag_clr;
reg [3:0] nxt_st;

always @* begin
  flag_set = `MCC_RST_FLAG;
  flag_set[`MCC_F_UP] = up_ev;
  flag_set[`MCC_F_DOWN] = down_ev;
  flag_set[`MCC_F_OVF] = auto_load & mul_ovf; // [R8]
  flag_set[`MCC_F_EMERG] = emerg_fall; // [R8]
  flag_set[`MCC_F_ZERO] = zero_ev; // [R8]
  flag_set[`MCC_F_DEMAG] = DEMAG_END_EV & run; // [R8]
  flag_set[`MCC_F_COMM] = comm; // [R8]
  flag_clr = `MCC_RST_FLAG;
  if (wr_flag) begin
    flag_clr = ~WDATA[`MCC_F_HI:0]; // [R22]
  end
  flag_clr[`MCC_F_UP] = flag_clr[`MCC_F_UP] | sw_up;
  flag_clr[`MCC_F_DOWN] = flag_clr[`MCC_F_DOWN] | sw_down;
end

// Prescaler saturates so a run of slow-down events cannot wrap to fast.
always @* begin
  nxt_st = st_ff;
  if (wr_pre) begin
    nxt_st = WDATA[`MCC_ST_HI:`MCC_ST_LO];
  end else if (hw_inc & ~hw_dec & (st_ff != `MCC_ST_MAX)) begin
    nxt_st = st_ff + `MCC_ST_ONE; // [R2] [R10]
  end else if (hw_dec & ~hw_inc & (st_ff != `MCC_ST_MIN)) begin
    nxt_st = st_ff - `MCC_ST_ONE; // [R2] [R11]
  end
end

wire en_ratio = mask_ff[`MCC_M_RATIO]; // [R5]
wire en_ovf = mask_ff[`MCC_M_OVF]; // [R5]
wire en_emerg = mask_ff[`MCC_M_EMERG]; // [R5]
wire en_zero = mask_ff[`MCC_M_ZERO]; // [R5]
// The demag source only exists while one of the demag enables is on.
wire en_demag = mask_ff[`MCC_M_DEMAG] & (HW_DEMAG_EN | SW_DEMAG_EN); // [R6]
wire en_comm = mask_ff[`MCC_M_COMM]; // [R5]
wire [5:0] irq_en = {en_ratio, en_ovf, en_emerg, en_zero, en_demag, en_comm};
wire [6:0] nxt_flag = (flag_ff & ~flag_clr) | flag_set;
// One ratio mask covers both directions, so the two flags are merged.
// The request follows the next flag value to save a cycle of latency.
wire [5:0] pend = {nxt_flag[`MCC_F_UP] | nxt_flag[`MCC_F_DOWN],
  nxt_flag[`MCC_F_OVF:0]};
wire nxt_irq = |(pend & irq_en); // [R5] [R22]

////////////////////////////////////////////////////////////////////////////////

always @(posedge CLOCK or negedge RESETN) begin
  if (!RESETN) begin
    sync1_ff <= 3'h7;
    sync2_ff <= 3'h7;
    emerg_prev_ff <= 1'b1;
  end else begin
    sync1_ff <= {EMERGENCY_N, CURR_COMP, HYST_COMP};
    sync2_ff <= sync1_ff;
    emerg_prev_ff <= emerg_n_s;
  end
end

// The unit reset bit clears this block only; the synchronisers keep
// running so the comparator readback stays valid across it.
always @(posedge CLOCK or negedge RESETN) begin
  if (!RESETN) begin
    sa_ff <= `MCC_RST_NIB;
    st_ff <= `MCC_RST_NIB;
    mask_ff <= `MCC_RST_SIX;
    flag_ff <= `MCC_RST_FLAG;
    ctl_ff <= `MCC_RST_BYTE;
    cmp_ff <= `MCC_RST_BYTE;
    phase_pre_ff <= `MCC_RST_SIX;
    phase_act_ff <= `MCC_RST_SIX;
    os2_pre_ff <= 1'b0;
    os2_act_ff <= 1'b0;
    shr_ff <= 1'b0;
    shl_ff <= 1'b0;
  end else if (soft_rst) begin
    // The reset bit clears itself together with everything else.
    sa_ff <= `MCC_RST_NIB; // [R13]
    st_ff <= `MCC_RST_NIB; // [R13]
    mask_ff <= `MCC_RST_SIX; // [R13]
    flag_ff <= `MCC_RST_FLAG; // [R13]
    ctl_ff <= `MCC_RST_BYTE; // [R13]
    cmp_ff <= `MCC_RST_BYTE; // [R13]
    phase_pre_ff <= `MCC_RST_SIX;
    phase_act_ff <= `MCC_RST_SIX;
    os2_pre_ff <= 1'b0;
    os2_act_ff <= 1'b0;
    shr_ff <= 1'b0;
    shl_ff <= 1'b0;
  end else begin
    if (wr_pre) begin
      sa_ff <= WDATA[`MCC_SA_HI:`MCC_SA_LO]; // [R1]
    end
    st_ff <= nxt_st;
    if (wr_mask) begin
      mask_ff <= WDATA[`MCC_M_WR_HI:0]; // [R3] [R4] [R5]
    end
    flag_ff <= nxt_flag;
    if (wr_ctl) begin
      ctl_ff <= WDATA; // [R12] [R14] [R17] [R18] [R19]
    end
    if (emerg_fall | ~emerg_n_s) begin
      ctl_ff[`MCC_C_MOE] <= 1'b0;
    end
    if (wr_cmp) begin
      cmp_ff <= WDATA; // [R18]
    end else if (auto_load) begin
      cmp_ff <= quotient; // [R20]
    end
    if (PHASE_WR) begin
      phase_pre_ff <= PHASE_DATA;
    end
    if (DEMAG_PWM_WR) begin
      os2_pre_ff <= DEMAG_PWM_DATA;
    end
    if (direct_load) begin
      phase_act_ff <= PHASE_DATA; // [R16]
      os2_act_ff <= DEMAG_PWM_WR ? DEMAG_PWM_DATA : os2_pre_ff; // [R16]
    end else if (comm) begin
      phase_act_ff <= phase_pre_ff; // [R15] [R21]
      os2_act_ff <= os2_pre_ff; // [R15] [R21]
    end
    shr_ff <= sw_up; // [R10]
    shl_ff <= sw_down; // [R11]
  end
end

////////////////////////////////////////////////////////////////////////////////

// Pin drive: polarity 1 means an active channel drives high.
always @(posedge CLOCK or negedge RESETN) begin
  if (!RESETN) begin
    out_ff <= `MCC_RST_SIX;
    oe_ff <= `MCC_RST_SIX;
    clk_en_ff <= 1'b0;
    irq_ff <= 1'b0;
  end else begin
    out_ff <= ~(phase_act_ff ^ POLARITY);
    oe_ff <= {6{output_enable_master & emerg_n_s & ~soft_rst}}; // [R12]
    clk_en_ff <= output_enable_master & ~direct & ~soft_rst; // [R12] [R16]
    irq_ff <= nxt_irq & ~soft_rst; // [R22]
  end
end

// Unused addresses read zero so software can probe the map safely.
reg [7:0] rd_mux;

always @* begin
  rd_mux = `MCC_RST_BYTE;
  case (ADDR)
    `MCC_A_PRESCALE: rd_mux = {sa_ff, st_ff}; // [R1] [R2]
    `MCC_A_MASK: rd_mux = {hyst_s, curr_s, mask_ff}; // [R3] [R4]
    `MCC_A_FLAG: rd_mux = {1'b0, flag_ff}; // [R7]
    `MCC_A_CTRL_A: rd_mux = ctl_ff;
    `MCC_A_COMPARE: rd_mux = cmp_ff;
    default: rd_mux = `MCC_RST_BYTE;
  endcase
end

// Read data stand for one cycle only and fall back to zero, so a stale
// value can never be mistaken for a fresh answer.
always @(posedge CLOCK or negedge RESETN) begin
  if (!RESETN) begin
    rdata_ff <= `MCC_RST_BYTE;
  end else if (RD) begin
    rdata_ff <= rd_mux;
  end else begin
    rdata_ff <= `MCC_RST_BYTE;
  end
end

////////////////////////////////////////////////////////////////////////////////

// Every output below is a register or a plain slice of one.
assign RDATA = rdata_ff;
assign MOTOR_OUT = out_ff;
assign MOTOR_OE = oe_ff;
assign TIMER_CLK_EN = clk_en_ff;
assign TIMER_SHIFT_R = shr_ff;
assign TIMER_SHIFT_L = shl_ff;
assign STEP_PRESCALE = st_ff;
assign SAMPLE_RATIO = sa_ff;
assign CURRENT_MODE = ctl_ff[`MCC_C_CURMODE]; // [R17]
assign SENSOR_MODE = ctl_ff[`MCC_C_SENSOR];
assign AUTO_COMMUTE = ctl_ff[`MCC_C_AUTO];
assign FILTER_EN = ctl_ff[`MCC_C_FILTER]; // [R19]
// The demag PWM select passes through in both modes; sensor mode does not gate it.
assign DEMAG_PWM_ACT = os2_act_ff; // [R14]
assign NEXT_COMPARE = cmp_ff;
assign UNIT_SOFT_RESET = soft_rst; // [R13]
assign IRQ_REQ = irq_ff;

endmodule // mcc_regs

/* File: pkg/mcc_consts.vh */
`ifndef MCC_CONSTS_VH
`define MCC_CONSTS_VH

// Register addresses on the plain register port.
`define MCC_ADDR_W 3
`define MCC_A_PRESCALE 3'h0
`define MCC_A_MASK 3'h1
`define MCC_A_FLAG 3'h2
`define MCC_A_CTRL_A 3'h3
`define MCC_A_COMPARE 3'h4

// Reset values.
`define MCC_RST_BYTE 8'h00
`define MCC_RST_NIB 4'h0
`define MCC_RST_SIX 6'h00
`define MCC_RST_FLAG 7'h00

// Ratio prescale register fields.
`define MCC_SA_HI 7
`define MCC_SA_LO 4
`define MCC_ST_HI 3
`define MCC_ST_LO 0
`define MCC_ST_MAX 4'hf
`define MCC_ST_MIN 4'h0
`define MCC_ST_ONE 4'h1

// Interrupt mask register fields.
`define MCC_M_HYST 7
`define MCC_M_CURR 6
`define MCC_M_RATIO 5
`define MCC_M_OVF 4
`define MCC_M_EMERG 3
`define MCC_M_ZERO 2
`define MCC_M_DEMAG 1
`define MCC_M_COMM 0
`define MCC_M_WR_HI 5

// Interrupt flag register fields.
`define MCC_F_RSVD 7
`define MCC_F_UP 6
`define MCC_F_DOWN 5
`define MCC_F_OVF 4
`define MCC_F_EMERG 3
`define MCC_F_ZERO 2
`define MCC_F_DEMAG 1
`define MCC_F_COMM 0
`define MCC_F_HI 6

// Control register A fields.
`define MCC_C_MOE 7
`define MCC_C_RST 6
`define MCC_C_SENSOR 5
`define MCC_C_DIRECT 4
`define MCC_C_CURMODE 3
`define MCC_C_AUTO 2
`define MCC_C_FILTER 1
`define MCC_C_CAPSEL 0

// Multiplier: compare = weight * capture / 32.
`define MCC_PROD_W 16
`define MCC_Q_HI 12
`define MCC_Q_LO 5
`define MCC_OVF_HI 15
`define MCC_OVF_LO 13

`endif

/* File: tb/mcc_bridge.sv */
module mcc_bridge (
  input wire hyst_set,
  input wire curr_set,
  input wire trip,
  output wire hyst_comp,
  output wire curr_comp,
  output wire emergency_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // The driver alarm is a plain level that stays low while the fault lasts.
  assign hyst_comp = hyst_set;
  assign curr_comp = curr_set;
  assign emergency_n = ~trip;
endmodule // mcc_bridge

/* File: tb/mcc_regs_sva.sv */
`include "mcc_consts.vh"
module mcc_regs_sva (
  input wire CLOCK,
  input wire RESETN,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire HYST_COMP,
  input wire CURR_COMP,
  input wire [5:0] MOTOR_OE,
  input wire TIMER_CLK_EN,
  input wire [3:0] STEP_PRESCALE,
  input wire CURRENT_MODE,
  input wire SENSOR_MODE,
  input wire AUTO_COMMUTE,
  input wire FILTER_EN,
  input wire UNIT_SOFT_RESET
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [2:0] age_ff;
  wire [2:0] nxt_age;
  wire ctl_wr;
  // Comparator reads wait after either reset; only the pin reset restarts the synchronisers.
  assign nxt_age = UNIT_SOFT_RESET ? 3'h0 : age_ff + {2'h0, age_ff != 3'h7};
  assign ctl_wr = WR && ADDR == `MCC_A_CTRL_A && !UNIT_SOFT_RESET;
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) age_ff <= 3'h0;
    else age_ff <= nxt_age;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////
  property p_flag_rsvd;
    RD && ADDR == `MCC_A_FLAG |=> !RDATA[7];
  endproperty
  a_flag_rsvd: assert property (p_flag_rsvd)
    else $error("flag bit 7 set");
  property p_hyst;
    RD && ADDR == `MCC_A_MASK && age_ff == 3'h7 && $stable(HYST_COMP) &&
      HYST_COMP == $past(HYST_COMP, 3) |=> RDATA[7] == $past(HYST_COMP);
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("hysteresis bit wrong");
  property p_curr;
    RD && ADDR == `MCC_A_MASK && age_ff == 3'h7 && $stable(CURR_COMP) &&
      CURR_COMP == $past(CURR_COMP, 3) |=> RDATA[6] == $past(CURR_COMP);
  endproperty
  a_curr: assert property (p_curr)
    else $error("current bit wrong");
  sequence s_ratio_wr;
    (WR && ADDR == 3'h0 && !UNIT_SOFT_RESET) ##1 !WR ##1 (RD && ADDR == 3'h0);
  endsequence
  property p_ratio_rw;
    s_ratio_wr |=> RDATA[7:4] == $past(WDATA[7:4], 3);
  endproperty
  a_ratio_rw: assert property (p_ratio_rw)
    else $error("ratio lost");
  property p_oe_off;
    WR && ADDR == `MCC_A_CTRL_A && !WDATA[7] |=> ##2 MOTOR_OE == 6'h00;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("outputs driven");
  property p_direct_clk;
    WR && ADDR == `MCC_A_CTRL_A && WDATA[4] |=> ##2 !TIMER_CLK_EN;
  endproperty
  a_direct_clk: assert property (p_direct_clk)
    else $error("timer clk on");
  sequence s_mode_wr;
    (ctl_wr && !WDATA[6]) ##1 !WR [*2];
  endsequence
  property p_mode;
    s_mode_wr |=> {CURRENT_MODE, SENSOR_MODE, AUTO_COMMUTE, FILTER_EN} ==
      {$past(WDATA[3], 3), $past(WDATA[5], 3), $past(WDATA[2], 3),
      $past(WDATA[1], 3)};
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode outputs wrong");
  sequence s_soft_done;
    ##1 UNIT_SOFT_RESET ##1
      (!UNIT_SOFT_RESET && MOTOR_OE == 6'h00 && STEP_PRESCALE == 4'h0);
  endsequence
  property p_soft;
    ctl_wr && WDATA[6] |-> s_soft_done;
  endproperty
  a_soft: assert property (p_soft)
    else $error("unit reset wrong");
endmodule // mcc_regs_sva
bind mcc_regs mcc_regs_sva i_sva (.CLOCK(CLOCK), .RESETN(RESETN),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .HYST_COMP(HYST_COMP), .CURR_COMP(CURR_COMP), .MOTOR_OE(MOTOR_OE),
  .TIMER_CLK_EN(TIMER_CLK_EN), .STEP_PRESCALE(STEP_PRESCALE),
  .CURRENT_MODE(CURRENT_MODE), .SENSOR_MODE(SENSOR_MODE),
  .AUTO_COMMUTE(AUTO_COMMUTE), .FILTER_EN(FILTER_EN),
  .UNIT_SOFT_RESET(UNIT_SOFT_RESET));

/* File: tb/mcc_regs_tb.sv */
`include "mcc_consts.vh"
module mcc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, pw = 1'b0;
  reg hs = 1'b0, trip = 1'b0, swd = 1'b0, sr_seen = 1'b0, sl_seen = 1'b0;
  reg dw = 1'b0;
  wire [3:0] sratio;
  wire [7:0] ncmp;
  wire dpa;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00, wgt = 8'h40, prv = 8'h10, lat = 8'h20;
  reg [4:0] ev = 5'h00;
  reg [5:0] pd = 6'h00, pol = 6'h3f;
  integer err_total = 0, checks = 0, i;
  wire [7:0] rdata;
  wire [5:0] mo, output_enable_master;
  wire [3:0] mode;
  wire hyst, curr, emerg_n, clk_en, shr, shl, irq;
  mcc_bridge i_far (.hyst_set(hs), .curr_set(1'b0), .trip(trip),
    .hyst_comp(hyst), .curr_comp(curr), .emergency_n(emerg_n));
  mcc_regs i_dut (.CLOCK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .HYST_COMP(hyst), .CURR_COMP(curr),
    .EMERGENCY_N(emerg_n), .COMMUTE_EV(ev[0]), .ZERO_CROSS_EV(ev[1]),
    .DEMAG_END_EV(ev[2]), .RATIO_UP_EV(ev[3]), .RATIO_DOWN_EV(ev[4]),
    .HW_DEMAG_EN(1'b0), .SW_DEMAG_EN(swd), .DEMAG_PWM_WR(dw),
    .DEMAG_PWM_DATA(1'b1), .PHASE_WR(pw), .PHASE_DATA(pd), .POLARITY(pol),
    .WEIGHT(wgt), .PREV_CAPTURE(prv), .LATEST_CAPTURE(lat), .MOTOR_OUT(mo),
    .MOTOR_OE(output_enable_master), .TIMER_CLK_EN(clk_en), .TIMER_SHIFT_R(shr),
    .TIMER_SHIFT_L(shl), .STEP_PRESCALE(), .SAMPLE_RATIO(sratio),
    .CURRENT_MODE(mode[3]), .SENSOR_MODE(mode[2]), .AUTO_COMMUTE(mode[1]),
    .FILTER_EN(mode[0]), .DEMAG_PWM_ACT(dpa), .NEXT_COMPARE(ncmp),
    .UNIT_SOFT_RESET(), .IRQ_REQ(irq));
  initial forever #12.5 clk = ~clk;
  // Shift pulses last one cycle, so they are latched for a later look.
  always @(posedge clk) begin
    if (shr) sr_seen <= 1'b1;
    if (shl) sl_seen <= 1'b1;
  end
  ////////////////////////////////////////
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task w(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task r(input [2:0] a, input [7:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", rdata, e);
    end
  endtask
  task p(input [4:0] m, input ph, input [5:0] d);
    begin
      @(posedge clk);
      ev <= m;
      pw <= ph;
      dw <= ph;
      pd <= d;
      @(posedge clk);
      ev <= 5'h00;
      pw <= 1'b0;
      dw <= 1'b0;
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total = err_total + 1;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) r(i[2:0], 8'h00);
    w(3'h5, 8'hff);
    r(3'h5, 8'h00);
    hs <= 1'b1;
    w(`MCC_A_MASK, 8'hff);
    r(`MCC_A_MASK, 8'hbf);
    w(`MCC_A_FLAG, 8'hff);
    r(`MCC_A_FLAG, 8'h00);
    w(`MCC_A_PRESCALE, 8'ha3);
    r(`MCC_A_PRESCALE, 8'ha3);
    chk("ratio", {4'h0, sratio}, 8'h0a);
    w(`MCC_A_CTRL_A, 8'h80);
    p(5'h08, 1'b0, 6'h00);
    r(`MCC_A_PRESCALE, 8'ha3);
    r(`MCC_A_FLAG, 8'h40);
    chk("irq", {7'h00, irq}, 8'h01);
    p(5'h01, 1'b0, 6'h00);
    r(`MCC_A_PRESCALE, 8'ha4);
    r(`MCC_A_FLAG, 8'h01);
    p(5'h10, 1'b0, 6'h00);
    p(5'h01, 1'b0, 6'h00);
    r(`MCC_A_PRESCALE, 8'ha3);
    chk("shift", {6'h00, sr_seen, sl_seen}, 8'h03);
    w(`MCC_A_MASK, 8'h02);
    w(`MCC_A_FLAG, 8'h00);
    p(5'h04, 1'b0, 6'h00);
    r(`MCC_A_FLAG, 8'h02);
    chk("irq", {7'h00, irq}, 8'h00);
    swd <= 1'b1;
    repeat (3) @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h01);
    w(`MCC_A_MASK, 8'h04);
    repeat (2) @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h00);
    p(5'h02, 1'b0, 6'h00);
    chk("irq", {7'h00, irq}, 8'h01);
    w(`MCC_A_MASK, 8'h08);
    w(`MCC_A_FLAG, 8'h00);
    trip <= 1'b1;
    repeat (6) @(posedge clk);
    chk("oe", {2'h0, output_enable_master}, 8'h00);
    chk("irq", {7'h00, irq}, 8'h01);
    r(`MCC_A_FLAG, 8'h08);
    trip <= 1'b0;
    w(`MCC_A_FLAG, 8'h00);
    repeat (3) @(posedge clk);
    w(`MCC_A_CTRL_A, 8'h80);
    p(5'h00, 1'b1, 6'h15);
    chk("out", {2'h0, mo}, 8'h00);
    chk("os2", {7'h00, dpa}, 8'h00);
    chk("oe", {2'h0, output_enable_master}, 8'h3f);
    p(5'h01, 1'b0, 6'h00);
    chk("out", {2'h0, mo}, 8'h15);
    chk("os2", {7'h00, dpa}, 8'h01);
    w(`MCC_A_CTRL_A, 8'h90);
    p(5'h00, 1'b1, 6'h2a);
    chk("out", {2'h0, mo}, 8'h2a);
    chk("clk_en", {7'h00, clk_en}, 8'h00);
    w(`MCC_A_CTRL_A, 8'h84);
    w(`MCC_A_FLAG, 8'h00);
    w(`MCC_A_PRESCALE, 8'h0f);
    p(5'h08, 1'b0, 6'h00);
    r(`MCC_A_PRESCALE, 8'h0f);
    p(5'h10, 1'b0, 6'h00);
    r(`MCC_A_PRESCALE, 8'h0e);
    r(`MCC_A_FLAG, 8'h60);
    w(`MCC_A_COMPARE, 8'h55);
    r(`MCC_A_COMPARE, 8'h00);
    p(5'h02, 1'b0, 6'h00);
    r(`MCC_A_COMPARE, 8'h20);
    w(`MCC_A_CTRL_A, 8'h85);
    p(5'h02, 1'b0, 6'h00);
    r(`MCC_A_COMPARE, 8'h40);
    wgt <= 8'hff;
    lat <= 8'hff;
    p(5'h02, 1'b0, 6'h00);
    r(`MCC_A_COMPARE, 8'hf0);
    chk("compare", ncmp, 8'hf0);
    r(`MCC_A_FLAG, 8'h74);
    w(`MCC_A_CTRL_A, 8'h40);
    repeat (3) @(posedge clk);
    r(`MCC_A_PRESCALE, 8'h00);
    r(`MCC_A_FLAG, 8'h00);
    w(`MCC_A_CTRL_A, 8'h2b);
    repeat (4) @(posedge clk);
    chk("mode", {4'h0, mode}, 8'h0d);
    report_and_stop;
  end
endmodule // mcc_regs_tb
